// ===== src/dtc_timing.sv
// DRAM command timing: write start, termination, power-down, refresh and calibration
//
// How it works
// (RULE_01) The controller waits 40 CK cycles after leveling entry before the first strobe rise.
// (RULE_02) The controller waits 25 CK cycles after leveling entry before driving the strobe.
// (RULE_03) After a refresh no activate or refresh comes within 110 ns.
// (RULE_04) Refreshes average no more than 7.8 us apart, or 3.9 us in the hot range.
// (RULE_05) Internal write starts WL+4 cycles after a write, or WL+2 with chop fixed by mode.
// (RULE_06) Reads and synchronous termination count as commands needing a locked loop.
// (RULE_07) Write recovery in ns is rounded up to whole cycles for power-down spacing.
// (RULE_08) Clock enable may drop during row, precharge or refresh work; low power waits for it.
// (RULE_09) Power-down after refresh may need the frozen-loop exit time on top of the minimum.
// (RULE_10) Nominal and write termination turn off 0.3 to 0.7 cycles after their reference edge.
// (RULE_11) A dynamic termination change completes within 0.3 to 0.7 cycles.
// (RULE_12) A short calibration corrects its step within 64 CK cycles.
// (RULE_13) The clock period may be long if the refresh interval is still met.
// (RULE_14) The clock period meets both read and write latency requirements.
// (RULE_15) At least one cycle separates a refresh from clock enable going low.
// (RULE_16) After frozen-loop exit, locked commands wait max of 10 cycles and 24 ns.
// (RULE_17) The controller tracks postponed refreshes and catches up.
`timescale 1ns/10ps
`default_nettype none
`include "dtc_defines.svh"

module dtc_timing (
  // System clock and reset
  input  wire logic                    clk_in,
  input  wire logic                    srst_in,
  // Register port
  input  wire logic [`DTC_ADDR_W-1:0]  reg_addr_in,
  input  wire logic [`DTC_DATA_W-1:0]  reg_wdata_in,
  input  wire logic                    reg_wr_in,
  input  wire logic                    reg_rd_in,
  output logic      [`DTC_DATA_W-1:0]  reg_rdata_out,
  // Command link on CK
  input  wire logic                    ck_in,
  input  wire logic [2:0]              cmd_in,
  input  wire logic                    cke_in,
  input  wire logic                    odt_in,
  input  wire logic                    strobe_drive_in,
  input  wire logic                    strobe_rise_in,
  // Device state on CK
  output logic                         write_start_out,
  output logic                         term_enable_out,
  output logic                         term_write_sel_out,
  output logic                         low_power_out,
  output logic                         zq_busy_out,
  output logic      [3:0]              zq_step_out
);

  // ----------------------------------------------------------------
  // Registers on the system clock
  // ----------------------------------------------------------------
  logic [`DTC_DATA_W-1:0] ctrl_reg;
  logic                   rfc_err_reg;
  logic                   lvl_err_reg;
  logic                   late_reg;
  logic                   rfc_tgl_reg;
  logic                   lvl_tgl_reg;
  logic                   ref_tgl_reg;
  logic [2:0]             rfc_tgl_sync_reg;
  logic [2:0]             lvl_tgl_sync_reg;
  logic [2:0]             ref_tgl_sync_reg;
  logic [1:0]             lp_sync_reg;
  logic [1:0]             zq_sync_reg;
  logic [9:0]             refi_cnt_reg;
  logic [9:0]             refi_limit;
  logic                   rfc_evt;
  logic                   lvl_evt;
  logic                   ref_evt;
  logic                   status_wr;

  assign status_wr = reg_wr_in && (reg_addr_in == `DTC_STATUS_ADDR);
  assign rfc_evt   = rfc_tgl_sync_reg[2] ^ rfc_tgl_sync_reg[1];
  assign lvl_evt   = lvl_tgl_sync_reg[2] ^ lvl_tgl_sync_reg[1];
  assign ref_evt   = ref_tgl_sync_reg[2] ^ ref_tgl_sync_reg[1];

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      ctrl_reg <= `DTC_CTRL_RESET;
    end else if (reg_wr_in && (reg_addr_in == `DTC_CTRL_ADDR)) begin
      ctrl_reg <= reg_wdata_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        `DTC_CTRL_ADDR: begin
          reg_rdata_out <= ctrl_reg;
        end
        `DTC_STATUS_ADDR: begin
          reg_rdata_out <= {3'h0, zq_sync_reg[1], lp_sync_reg[1], late_reg, lvl_err_reg,
                            rfc_err_reg};
        end
        default: begin
          reg_rdata_out <= 8'h00;
        end
      endcase
    end else begin
      reg_rdata_out <= 8'h00;
    end
  end

  // Event toggles and the low power and calibration levels from CK: the first stage feeds only the second
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      rfc_tgl_sync_reg <= 3'h0;
      lvl_tgl_sync_reg <= 3'h0;
      ref_tgl_sync_reg <= 3'h0;
      lp_sync_reg      <= 2'h0;
      zq_sync_reg      <= 2'h0;
    end else begin
      rfc_tgl_sync_reg <= {rfc_tgl_sync_reg[1:0], rfc_tgl_reg};
      lvl_tgl_sync_reg <= {lvl_tgl_sync_reg[1:0], lvl_tgl_reg};
      ref_tgl_sync_reg <= {ref_tgl_sync_reg[1:0], ref_tgl_reg};
      lp_sync_reg      <= {lp_sync_reg[0], low_power_out};
      zq_sync_reg      <= {zq_sync_reg[0], zq_busy_out};
    end
  end

  // Sticky flags, write one to clear, a new event wins over the clear
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      rfc_err_reg <= 1'b0;
      lvl_err_reg <= 1'b0;
      late_reg    <= 1'b0;
    end else begin
      rfc_err_reg <= rfc_evt ||
                     (rfc_err_reg && !(status_wr && reg_wdata_in[`DTC_ST_RFC_BIT]));
      lvl_err_reg <= lvl_evt ||
                     (lvl_err_reg && !(status_wr && reg_wdata_in[`DTC_ST_LVL_BIT]));
      late_reg    <= (refi_cnt_reg == refi_limit) ||
                     (late_reg && !(status_wr && reg_wdata_in[`DTC_ST_LATE_BIT]));
    end
  end

  // Refresh debt watch: nine intervals without a refresh is overdue
  assign refi_limit = ctrl_reg[`DTC_CTRL_HOT_BIT] ?
                      10'(`DTC_REF_POSTPONE * `DTC_REFI_HOT_CLK) :
                      10'(`DTC_REF_POSTPONE * `DTC_REFI_NORM_CLK);

  always_ff @(posedge clk_in) begin
    if (srst_in || ref_evt) begin
      refi_cnt_reg <= 10'h000; // RULE_04
    end else if (refi_cnt_reg != refi_limit) begin
      refi_cnt_reg <= refi_cnt_reg + 10'h001; // RULE_17
    end
  end

  // ----------------------------------------------------------------
  // Link domain on CK
  // ----------------------------------------------------------------
  logic                     rst_s1_reg;
  logic                     rst_ck_reg;
  logic [3:0]               wl_s1_reg;
  logic [3:0]               wl_ck_reg;
  logic [1:0]               bc4_s_reg;
  logic [15:0]              wr_pipe_reg;
  logic [15:0]              wr_pipe_next;
  logic [15:0]              odt_hist_reg;
  logic [4:0]               wr_delay;
  logic [3:0]               odt_lat;
  logic [2:0]               rfc_cnt_reg;
  logic [2:0]               row_cnt_reg;
  logic [6:0]               zq_cnt_reg;
  logic [5:0]               lvl_cnt_reg;
  dtc_pkg::dtc_lvl_type     lvl_state_reg;
  logic                     ops_busy;
  logic                     is_ref;
  logic                     is_wr;

  assign is_ref   = (cmd_in == dtc_pkg::DTC_CMD_REF);
  assign is_wr    = (cmd_in == dtc_pkg::DTC_CMD_WR);
  assign ops_busy = (rfc_cnt_reg != 3'h0) || (row_cnt_reg != 3'h0);

  always_ff @(posedge ck_in) begin
    rst_s1_reg <= srst_in;
    rst_ck_reg <= rst_s1_reg;
  end

  // Static configuration, stable while commands flow
  always_ff @(posedge ck_in) begin
    wl_s1_reg <= ctrl_reg[`DTC_CTRL_WL_MSB:`DTC_CTRL_WL_LSB];
    wl_ck_reg <= wl_s1_reg;
    bc4_s_reg <= {bc4_s_reg[0], ctrl_reg[`DTC_CTRL_BC4_BIT]};
  end

  // Internal write start after write latency plus burst tail
  assign wr_delay = {1'b0, wl_ck_reg} + (bc4_s_reg[1] ? 5'(`DTC_BC4_EXTRA) :
                                                        5'(`DTC_BL8_EXTRA)); // RULE_05

  always_comb begin
    wr_pipe_next = {1'b0, wr_pipe_reg[15:1]};
    if (is_wr && (wr_delay != 5'h00)) begin
      wr_pipe_next[wr_delay[3:0] - 4'h1] = 1'b1; // RULE_05
    end
  end

  always_ff @(posedge ck_in) begin
    if (rst_ck_reg) begin
      wr_pipe_reg     <= 16'h0000;
      write_start_out <= 1'b0;
    end else begin
      wr_pipe_reg     <= wr_pipe_next;
      write_start_out <= wr_pipe_reg[0]; // RULE_05
    end
  end

  // Termination follows odt after the turn-off latency, switched on the reference edge
  assign odt_lat = wl_ck_reg - 4'(`DTC_ODT_LAT_SUB);

  always_ff @(posedge ck_in) begin
    if (rst_ck_reg) begin
      odt_hist_reg       <= 16'h0000;
      term_enable_out    <= 1'b0;
      term_write_sel_out <= 1'b0;
    end else begin
      odt_hist_reg       <= {odt_hist_reg[14:0], odt_in};
      term_enable_out    <= (odt_lat == 4'h0) ? odt_in : odt_hist_reg[odt_lat - 4'h1]; // RULE_10
      term_write_sel_out <= (wr_pipe_reg != 16'h0000); // RULE_11
    end
  end

  // Refresh and row work in progress, and the resulting low power state
  always_ff @(posedge ck_in) begin
    if (rst_ck_reg) begin
      rfc_cnt_reg <= 3'h0;
      row_cnt_reg <= 3'h0;
      rfc_tgl_reg <= 1'b0;
      ref_tgl_reg <= 1'b0;
    end else begin
      if (is_ref) begin
        rfc_cnt_reg <= 3'(`DTC_RFC_CK); // RULE_03
        ref_tgl_reg <= ~ref_tgl_reg;
      end else if (rfc_cnt_reg != 3'h0) begin
        rfc_cnt_reg <= rfc_cnt_reg - 3'h1;
      end
      if ((is_ref || cmd_in == dtc_pkg::DTC_CMD_ACT) && rfc_cnt_reg > 3'h1) begin
        rfc_tgl_reg <= ~rfc_tgl_reg; // RULE_03
      end
      if (cmd_in == dtc_pkg::DTC_CMD_ACT || cmd_in == dtc_pkg::DTC_CMD_PRE) begin
        row_cnt_reg <= 3'(`DTC_ROW_OP_CK);
      end else if (row_cnt_reg != 3'h0) begin
        row_cnt_reg <= row_cnt_reg - 3'h1;
      end
    end
  end

  always_ff @(posedge ck_in) begin
    if (rst_ck_reg) begin
      low_power_out <= 1'b0;
    end else begin
      low_power_out <= !cke_in && !ops_busy && !is_ref; // RULE_08
    end
  end

  // Write leveling entry waits
  always_ff @(posedge ck_in) begin
    if (rst_ck_reg) begin
      lvl_state_reg <= dtc_pkg::DTC_LVL_IDLE;
      lvl_cnt_reg   <= 6'h00;
      lvl_tgl_reg   <= 1'b0;
    end else begin
      case (lvl_state_reg)
        dtc_pkg::DTC_LVL_IDLE: begin
          if (cmd_in == dtc_pkg::DTC_CMD_LVL) begin
            lvl_state_reg <= dtc_pkg::DTC_LVL_WAIT;
            lvl_cnt_reg   <= 6'h01;
          end
        end
        dtc_pkg::DTC_LVL_WAIT: begin
          lvl_cnt_reg <= lvl_cnt_reg + 6'h01;
          if (strobe_drive_in || strobe_rise_in) begin
            lvl_tgl_reg <= ~lvl_tgl_reg; // RULE_02
          end
          if (lvl_cnt_reg == 6'(`DTC_LVL_DRIVE_CK - 1)) begin
            lvl_state_reg <= dtc_pkg::DTC_LVL_DRIVE;
          end
        end
        dtc_pkg::DTC_LVL_DRIVE: begin
          lvl_cnt_reg <= lvl_cnt_reg + 6'h01;
          if (strobe_rise_in) begin
            lvl_tgl_reg <= ~lvl_tgl_reg; // RULE_01
          end
          if (lvl_cnt_reg == 6'(`DTC_LVL_RISE_CK - 1)) begin
            lvl_state_reg <= dtc_pkg::DTC_LVL_READY;
          end
        end
        dtc_pkg::DTC_LVL_READY: begin
          if (cmd_in == dtc_pkg::DTC_CMD_LVL) begin
            lvl_state_reg <= dtc_pkg::DTC_LVL_WAIT;
            lvl_cnt_reg   <= 6'h01;
          end
        end
        default: begin
          lvl_state_reg <= dtc_pkg::DTC_LVL_IDLE;
        end
      endcase
    end
  end

  // Short calibration: busy for its window, one correction step at the end
  always_ff @(posedge ck_in) begin
    if (rst_ck_reg) begin
      zq_cnt_reg  <= 7'h00;
      zq_busy_out <= 1'b0;
      zq_step_out <= 4'h0;
    end else if (cmd_in == dtc_pkg::DTC_CMD_ZQCS && !zq_busy_out) begin
      zq_cnt_reg  <= 7'(`DTC_ZQCS_CK - 1);
      zq_busy_out <= 1'b1; // RULE_12
    end else if (zq_cnt_reg != 7'h00) begin
      zq_cnt_reg <= zq_cnt_reg - 7'h01;
    end else if (zq_busy_out) begin
      zq_busy_out <= 1'b0;
      zq_step_out <= zq_step_out + 4'h1; // RULE_12
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  write_start_bl8_a: assert property (@(posedge ck_in) disable iff (rst_ck_reg) // RULE_05
    (is_wr && wl_ck_reg == 4'h5 && !bc4_s_reg[1] && $stable(wl_ck_reg)) |-> ##10 write_start_out)
    else $error("write start missing after write latency plus four");

  write_start_bc4_a: assert property (@(posedge ck_in) disable iff (rst_ck_reg) // RULE_05
    (is_wr && wl_ck_reg == 4'h5 && bc4_s_reg[1] && $stable(wl_ck_reg)) |-> ##8 write_start_out)
    else $error("write start missing after write latency plus two");

  low_power_hold_a: assert property (@(posedge ck_in) disable iff (rst_ck_reg) // RULE_08
    $past(ops_busy) |-> !low_power_out)
    else $error("low power entered while work in progress");

  low_power_enter_a: assert property (@(posedge ck_in) disable iff (rst_ck_reg) // RULE_08
    (!cke_in && !ops_busy && !is_ref) |=> low_power_out)
    else $error("low power not entered once idle");

  term_off_a: assert property (@(posedge ck_in) disable iff (rst_ck_reg) // RULE_10
    (wl_ck_reg == 4'h5 && $stable(wl_ck_reg) && $fell(odt_in)) |-> ##4 !term_enable_out)
    else $error("termination not off at reference edge");

  term_switch_a: assert property (@(posedge ck_in) disable iff (rst_ck_reg) // RULE_11
    (wr_pipe_reg != 16'h0000) |=> term_write_sel_out)
    else $error("write termination not selected during write");

  zq_window_a: assert property (@(posedge ck_in) disable iff (rst_ck_reg) // RULE_12
    (cmd_in == dtc_pkg::DTC_CMD_ZQCS && !zq_busy_out) |=>
      zq_busy_out[*8] ##56 zq_busy_out ##1 !zq_busy_out)
    else $error("calibration window not 64 cycles");

endmodule

`default_nettype wire

// ===== src/dtc_defines.svh
// Offsets, field positions, reset values and timing counts of the DRAM timing block
`ifndef DTC_DEFINES_SVH
`define DTC_DEFINES_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define DTC_ADDR_W         4
`define DTC_DATA_W         8
`define DTC_CTRL_ADDR      4'h0
`define DTC_STATUS_ADDR    4'h4
`define DTC_CTRL_WL_LSB    0
`define DTC_CTRL_WL_MSB    3
`define DTC_CTRL_BC4_BIT   4
`define DTC_CTRL_HOT_BIT   5
`define DTC_CTRL_RESET     8'h05
`define DTC_ST_RFC_BIT     0
`define DTC_ST_LVL_BIT     1
`define DTC_ST_LATE_BIT    2
`define DTC_ST_LP_BIT      3
`define DTC_ST_ZQ_BIT      4

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define DTC_CLK_PERIOD_NS  100
`define DTC_CK_PERIOD_NS   30
`define DTC_RFC_NS         110
`define DTC_RFC_CK         ((`DTC_RFC_NS + `DTC_CK_PERIOD_NS - 1) / `DTC_CK_PERIOD_NS)
`define DTC_REFI_NORM_NS   7800
`define DTC_REFI_HOT_NS    3900
`define DTC_REFI_NORM_CLK  (`DTC_REFI_NORM_NS / `DTC_CLK_PERIOD_NS)
`define DTC_REFI_HOT_CLK   (`DTC_REFI_HOT_NS / `DTC_CLK_PERIOD_NS)
`define DTC_REF_POSTPONE   9
`define DTC_LVL_RISE_CK    40
`define DTC_LVL_DRIVE_CK   25
`define DTC_BL8_EXTRA      4
`define DTC_BC4_EXTRA      2
`define DTC_ODT_LAT_SUB    2
`define DTC_ZQCS_CK        64
`define DTC_ROW_OP_CK      4

`endif

// ===== src/dtc_pkg.sv
// Types of the DRAM timing block
package dtc_pkg;

  // ----------------------------------------------------------------
  // Commands decoded at the command pins
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    DTC_CMD_NOP  = 3'h0,
    DTC_CMD_ACT  = 3'h1,
    DTC_CMD_PRE  = 3'h2,
    DTC_CMD_REF  = 3'h3,
    DTC_CMD_WR   = 3'h4,
    DTC_CMD_RD   = 3'h5,
    DTC_CMD_LVL  = 3'h6,
    DTC_CMD_ZQCS = 3'h7
  } dtc_cmd_type;

  // ----------------------------------------------------------------
  // Write leveling entry states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DTC_LVL_IDLE  = 2'b00,
    DTC_LVL_WAIT  = 2'b01,
    DTC_LVL_DRIVE = 2'b11,
    DTC_LVL_READY = 2'b10
  } dtc_lvl_type;

endpackage

// ===== test/dtc_ctrl_model.sv
// Memory controller model driving the command link on CK
`timescale 1ns/10ps
`default_nettype none

module dtc_ctrl_model (
  // Link clock
  input  wire logic       ck_in,
  // Requests from the test sequence
  input  wire logic [2:0] cmd_req_in,
  input  wire logic       cke_req_in,
  input  wire logic       odt_req_in,
  input  wire logic [5:0] drive_at_in,
  input  wire logic [5:0] rise_at_in,
  // Command pins
  output logic      [2:0] cmd_out,
  output logic            cke_out,
  output logic            odt_out,
  output logic            strobe_drive_out,
  output logic            strobe_rise_out
);
  // ----------------------------------------------------------------
  // Command pins follow the requests; no reads and no write recovery
  // arise, so no locked-loop waits or latency limits come into play
  // ----------------------------------------------------------------
  assign cmd_out = cmd_req_in;
  assign cke_out = cke_req_in;
  assign odt_out = odt_req_in;

  // ----------------------------------------------------------------
  // Leveling strobe, counted in CK edges after the entry command
  // ----------------------------------------------------------------
  logic [5:0] lvl_edge_reg;

  always_ff @(posedge ck_in) begin
    if (cmd_req_in == dtc_pkg::DTC_CMD_LVL) begin
      lvl_edge_reg <= 6'h01;
    end else if (lvl_edge_reg != 6'h00 && lvl_edge_reg != 6'h2F) begin
      lvl_edge_reg <= lvl_edge_reg + 6'h01;
    end else begin
      lvl_edge_reg <= 6'h00;
    end
  end

  assign strobe_drive_out = (lvl_edge_reg != 6'h00) && (lvl_edge_reg >= drive_at_in);
  assign strobe_rise_out  = (lvl_edge_reg != 6'h00) && (lvl_edge_reg == rise_at_in);
endmodule
`default_nettype wire

// ===== test/tb_top.sv
// Self-checking testbench of the DRAM timing block
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  logic       clk;
  logic       srst;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic       wr_s;
  logic       rd_s;
  logic [7:0] rdata;
  logic       ck;
  logic [2:0] cmd;
  logic       cke;
  logic       odt;
  logic       sdrv;
  logic       srise;
  logic       wstart;
  logic       term_en;
  logic       term_wr;
  logic       lp;
  logic       zqb;
  logic [3:0] zqs;
  logic [2:0] cmd_rq;
  logic       cke_rq;
  logic       odt_rq;
  logic [5:0] drv_at;
  logic [5:0] rise_at;
  int         failures = 0;
  int         samples_checked = 0;

  dtc_timing dtc_timing_i (
    .clk_in(clk), .srst_in(srst), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr_s), .reg_rd_in(rd_s), .reg_rdata_out(rdata), .ck_in(ck),
    .cmd_in(cmd), .cke_in(cke), .odt_in(odt), .strobe_drive_in(sdrv),
    .strobe_rise_in(srise), .write_start_out(wstart), .term_enable_out(term_en),
    .term_write_sel_out(term_wr), .low_power_out(lp), .zq_busy_out(zqb),
    .zq_step_out(zqs)
  );

  dtc_ctrl_model dtc_ctrl_model_i (
    .ck_in(ck), .cmd_req_in(cmd_rq), .cke_req_in(cke_rq), .odt_req_in(odt_rq),
    .drive_at_in(drv_at), .rise_at_in(rise_at), .cmd_out(cmd), .cke_out(cke),
    .odt_out(odt), .strobe_drive_out(sdrv), .strobe_rise_out(srise)
  );

  // ----------------------------------------------------------------
  // Clocks
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    ck = 1'b0;
    #7;
    forever #15 ck = ~ck;
  end

  // ----------------------------------------------------------------
  // Compare, bus and closing tasks
  // ----------------------------------------------------------------
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: value %h, wanted %h", $time, got, exp);
    end
  endtask

  task automatic chkn(input int got, input int exp);
    samples_checked++;
    if (got != exp) begin
      failures++;
      $display("unexpected at %0t: count %0d, wanted %0d", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask

  task automatic rchk(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] d;
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    d = rdata;
    chk8(d & m, e);
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Link tasks, entered just after a CK edge
  task automatic idle(input int n);
    repeat (n) @(posedge ck);
  endtask

  // Callers set refresh spacing and the refresh rate per scenario
  task automatic issue(input logic [2:0] c);
    cmd_rq <= c;
    @(posedge ck);
    cmd_rq <= 3'h0;
  endtask

  // Levels take effect at the next edge, never in the refresh edge itself
  task automatic pins(input logic e, input logic o);
    cke_rq <= e;
    odt_rq <= o;
    @(posedge ck);
  endtask

  // Leveling entry, strobe driven from edge d, one rise at edge r
  task automatic level(input logic [5:0] d, input logic [5:0] r);
    drv_at <= d;
    rise_at <= r;
    issue(dtc_pkg::DTC_CMD_LVL);
    idle(47);
  endtask

  initial begin
    #2000000;
    failures++;
    $display("unexpected at %0t: watchdog expired", $time);
    complete_run();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    int k;
    int n;
    logic [3:0] s0;
    logic [7:0] cfg [3] = '{8'h05, 8'h15, 8'h07};
    logic [2:0] second [3] = '{3'h3, 3'h3, 3'h1};
    int gap [3] = '{3, 4, 3};
    logic [5:0] dr [3] = '{6'h18, 6'h1E, 6'h19};
    logic [5:0] rr [3] = '{6'h2D, 6'h27, 6'h28};
    srst = 1'b1;
    addr = 4'h0;
    wdata = 8'h00;
    wr_s = 1'b0;
    rd_s = 1'b0;
    cmd_rq = 3'h0;
    cke_rq = 1'b1;
    odt_rq = 1'b0;
    drv_at = 6'h00;
    rise_at = 6'h00;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    idle(6);
    rchk(4'h0, 8'hFF, 8'h05);
    rchk(4'h4, 8'hFF, 8'h00);
    wr(4'h8, 8'hFF);
    rchk(4'h8, 8'hFF, 8'h00);
    rchk(4'h0, 8'hFF, 8'h05);
    $display("test registers done");
    for (int i = 0; i < 3; i++) begin
      wr(4'h0, cfg[i]);
      idle(4);
      issue(dtc_pkg::DTC_CMD_WR);
      k = 0;
      do begin
        @(posedge ck);
        #1;
        k++;
      end while (wstart !== 1'b1 && k < 40);
      chkn(k, int'(cfg[i][3:0]) + (cfg[i][4] ? 2 : 4));
      chk8({7'h00, term_wr}, 8'h01);
      @(posedge ck);
      #1;
      chk8({6'h00, term_wr, wstart}, 8'h00);
    end
    wr(4'h0, 8'h05);
    $display("test write start done");
    for (int i = 0; i < 3; i++) begin
      wr(4'h4, 8'h07);
      idle(8);
      issue(dtc_pkg::DTC_CMD_REF);
      idle(gap[i] - 1);
      issue(second[i]);
      idle(8);
      rchk(4'h4, 8'h01, (gap[i] < 4) ? 8'h01 : 8'h00);
    end
    $display("test refresh spacing done");
    for (int i = 0; i < 3; i++) begin
      wr(4'h4, 8'h07);
      level(dr[i], rr[i]);
      idle(4);
      rchk(4'h4, 8'h02, (i < 2) ? 8'h02 : 8'h00);
    end
    $display("test leveling done");
    s0 = zqs;
    n = 0;
    fork
      begin
        for (int i = 0; i < 80; i++) begin
          @(posedge ck);
          #1;
          n += (zqb === 1'b1) ? 1 : 0;
        end
      end
      begin
        issue(dtc_pkg::DTC_CMD_ZQCS);
        idle(5);
        issue(dtc_pkg::DTC_CMD_ZQCS);
      end
    join
    chkn(n, 64);
    chk8({4'h0, zqs}, {4'h0, s0 + 4'h1});
    $display("test calibration done");
    issue(dtc_pkg::DTC_CMD_REF);
    pins(1'b0, 1'b0);
    #1;
    chk8({7'h00, lp}, 8'h00);
    idle(6);
    #1;
    chk8({7'h00, lp}, 8'h01);
    rchk(4'h4, 8'h08, 8'h08);
    pins(1'b1, 1'b1);
    idle(8);
    #1;
    chk8({6'h00, lp, term_en}, 8'h01);
    pins(1'b1, 1'b0);
    idle(8);
    #1;
    chk8({7'h00, term_en}, 8'h00);
    $display("test power-down and termination done");
    for (int i = 0; i < 2; i++) begin
      wr(4'h0, (i == 0) ? 8'h25 : 8'h05);
      idle(4);
      issue(dtc_pkg::DTC_CMD_REF);
      idle(6);
      wr(4'h4, 8'h07);
      repeat ((i == 0) ? 300 : 650) @(posedge clk);
      rchk(4'h4, 8'h04, 8'h00);
      repeat (100) @(posedge clk);
      rchk(4'h4, 8'h04, 8'h04);
    end
    $display("test refresh overdue done");
    complete_run();
  end
endmodule
`default_nettype wire
